// >>> dv/tcc_checker.sv
`timescale 1ns/1ps
module tcc_checker (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        standby,
  input wire logic [5:0]  bus_addr,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic [14:0] flags_o
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n || standby);
  sequence s_rd_lo(o);
    ce && bus_rd && bus_addr[2:0] == o && bus_addr < 6'h28;
  endsequence
  // flags held over the read so a one-cycle output stage cannot skew the compare
  sequence s_flag_rd;
    ce && bus_rd && bus_addr == 6'h02 && $stable(flags_o[2:0]) ##1 $stable(flags_o[2:0]);
  endsequence
  a_reset_out: assert property (
    disable iff (1'b0) !rst_n || standby |=> flags_o == 15'h0 && bus_rdata == 16'h0)
    else $error("outputs not cleared");
  a_rdata_holds: assert property (
    !(ce && bus_rd) |=> $stable(bus_rdata))
    else $error("read data moved");
  a_ctrl_top_bit: assert property (s_rd_lo(3'h0) |=> bus_rdata[7])
    else $error("control bit 7 low");
  a_low_buf_zero: assert property (
    ce && bus_rd && bus_addr < 6'h18 && bus_addr[2:1] == 2'h3 |=> bus_rdata == 16'h0)
    else $error("absent buffer not zero");
  a_unmapped_zero: assert property (
    ce && bus_rd && bus_addr > 6'h2a |=> bus_rdata == 16'h0)
    else $error("unmapped read not zero");
  a_flags_sticky: assert property (
    !(bus_wr && bus_addr[2:0] == 3'h2) |=> (flags_o & $past(flags_o)) == $past(flags_o))
    else $error("flag dropped");
  a_freeze_flags: assert property (!ce |=> $stable(flags_o))
    else $error("flags moved while frozen");
  a_flag_readback: assert property (
    s_flag_rd |-> bus_rdata[2:0] == flags_o[2:0])
    else $error("flag read mismatch");
endmodule
bind tcc_top tcc_checker chk_u (.ref_clk, .rst_n, .ce, .standby, .bus_addr, .bus_wr,
  .bus_rd, .bus_rdata, .flags_o);

// >>> dv/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [1:0] sel,
  input  wire logic [4:0] req_a,
  input  wire logic [4:0] req_b,
  output logic      [3:0] ext_clk,
  output logic      [4:0] cap_a,
  output logic      [4:0] cap_b,
  output logic            busy
);
  logic [3:0] left_r;
  logic [1:0] ph_r;
  assign busy = left_r != 4'h0;
  always_ff @(posedge ref_clk)
    cap_a <= req_a;
  always_ff @(posedge ref_clk)
    cap_b <= req_b;
  // 3 cycles a level clears the 2-cycle minimum; even burst leaves the clock idle low
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      left_r <= 4'h0;
      ph_r <= 2'h0;
      ext_clk <= 4'h0;
    end
    else if (go)
      left_r <= 4'h8;
    else if (busy)
    begin
      ph_r <= ph_r == 2'h2 ? 2'h0 : ph_r + 2'h1;
      if (ph_r == 2'h2)
      begin
        ext_clk[sel] <= ~ext_clk[sel];
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule

// >>> dv/timer_channel_compare_capture_clocking_tb.sv
`timescale 1ns/1ps
module timer_channel_compare_capture_clocking_tb;
  logic        ref_clk;
  logic        rst_n;
  logic        ce;
  logic        standby;
  logic [5:0]  bus_addr;
  logic        bus_wr;
  logic        bus_rd;
  logic [1:0]  bus_be;
  logic [15:0] bus_wdata;
  logic [3:0]  ext_clk;
  logic [4:0]  cap_a;
  logic [15:0] bus_rdata;
  logic [14:0] flags_o;
  logic        go;
  logic [1:0]  sel;
  logic [4:0]  req_a;
  logic [4:0]  req_b;
  logic [4:0]  cap_b;
  logic        busy;
  logic [15:0] mir [64];
  logic [15:0] q;
  logic [15:0] v;
  int          miscompares;
  int          cmp_count;
  int          cyc;
  int          seed;
  tcc_top dut_u (.ref_clk, .rst_n, .ce, .standby, .bus_addr, .bus_wr, .bus_rd, .bus_be,
    .bus_wdata, .ext_clock_a(ext_clk[0]), .ext_clock_b(ext_clk[1]),
    .ext_clock_c(ext_clk[2]), .ext_clock_d(ext_clk[3]), .cap_in_a(cap_a),
    .cap_in_b(cap_b), .bus_rdata, .flags_o);
  tcc_pin_model pm_u (.ref_clk, .rst_n, .go, .sel, .req_a, .req_b, .ext_clk, .cap_a,
    .cap_b, .busy);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic results();
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic mir_init();
    foreach (mir[i])
      mir[i] = (i < 40 && i % 8 > 3 && (i > 23 || i % 8 < 6)) ? 16'hffff : 16'h0;
    for (int c = 0; c < 5; c++)
    begin
      mir[8*c] = 16'h80;
      mir[8*c+1] = 16'h88;
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [1:0] be, input logic [15:0] d);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}};
    tick(1);
    {bus_addr, bus_be, bus_wdata, bus_wr} = {a, be, d, 1'b1};
    tick(1);
    bus_wr = 1'b0;
    mir[a] = (mir[a] & ~m) | (d & m);
    if (a < 6'h28 && a[2:1] == 2'h0)
      mir[a] = mir[a] | {8'h0, 4'h8, a[0], 3'h0};
  endtask
  task automatic rd(input logic [5:0] a);
    tick(1);
    {bus_addr, bus_rd} = {a, 1'b1};
    tick(1);
    bus_rd = 1'b0;
    q = bus_rdata;
  endtask
  task automatic scan(input int lo, input int hi);
    for (int a = lo; a < hi; a++)
      if (a % 8 != 2 && a % 8 != 3)
      begin
        rd(6'(a));
        check("init_val", q, mir[a]);
      end
  endtask
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      results();
    end
  end
  initial
  begin
    {rst_n, ce, standby, bus_addr, bus_wr, bus_rd, bus_be, bus_wdata, go, sel, req_a} = '0;
    req_b = 5'h0;
    seed = $urandom(51680);
    mir_init();
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    ce = 1'b1;
    scan(0, 48);
    for (int a = 0; a < 40; a++)
      if (a % 8 != 2 && a % 8 != 3 && (a > 23 || a % 8 < 6))
      begin
        wr(6'(a), a % 8 < 2 ? 2'h1 : 2'h3, a % 8 < 2 ? 16'($urandom % 256) : 16'($urandom));
        if (a % 8 > 3)
          wr(6'(a), 2'($urandom_range(1, 2)), 16'($urandom));
        rd(6'(a));
        check("reg_rw", q, mir[a]);
      end
    for (int c = 0; c < 5; c++)
    begin
      wr(6'(8 * c), 2'h1, 16'h0);
      wr(6'(8 * c + 1), 2'h1, 16'h0);
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(6'h0, 2'h1, k ? 16'h40 : 16'h20);
      wr(6'h4, 2'h3, k ? 16'h30 : 16'h10);
      wr(6'h5, 2'h3, k ? 16'h10 : 16'h30);
      wr(6'h3, 2'h3, 16'h0);
      wr(6'h2, 2'h1, 16'h0);
      for (int w = 0; w < 99 && flags_o[k] !== 1'b1; w++)
        tick(1);
      for (int i = 0; i < 4; i++)
      begin
        rd(6'h3);
        check("clear_bound", 16'(q <= 16'h10), 16'h1);
      end
      check("match_flag", 16'(flags_o[k]), 16'h1);
      check("other_flag", 16'(flags_o[1-k]), 16'h0);
    end
    wr(6'h0, 2'h1, 16'h0);
    wr(6'h3, 2'h3, 16'hfff0);
    wr(6'h2, 2'h1, 16'h0);
    check("no_ovf", 16'(flags_o[2]), 16'h0);
    tick(30);
    check("ovf", 16'(flags_o[2]), 16'h1);
    rd(6'h2);
    check("ovf_read", q & 16'h4, 16'h4);
    for (int k = 0; k < 4; k++)
    begin
      wr(6'h8, 2'h1, 16'(k));
      wr(6'hb, 2'h3, 16'h0);
      tick(64);
      rd(6'hb);
      v = 16'(64 >> k);
      check("prescale", 16'(q >= v && q <= v + 16'h2), 16'h1);
    end
    // channel 0 has long since matched both registers and wrapped, so its flags stay put
    rd(6'h2);
    check("flag_read", q, 16'h00ff);
    wr(6'h8, 2'h1, 16'h0);
    rd(6'hb);
    v = q;
    ce = 1'b0;
    tick(20);
    ce = 1'b1;
    rd(6'hb);
    check("freeze", q, v + 16'h2);
    for (int p = 0; p < 4; p++)
    begin
      wr(6'h8, 2'h1, 16'(4 + p + 8 * (p % 3)));
      wr(6'hb, 2'h3, 16'h0);
      {sel, go} = {2'(p), 1'b1};
      tick(1);
      go = 1'b0;
      for (int w = 0; w < 99 && busy; w++)
        tick(1);
      tick(8);
      rd(6'hb);
      check("ext_count", q, p % 3 == 2 ? 16'h8 : 16'h4);
    end
    // counter of channel 3 held still by an idle external clock
    wr(6'h19, 2'h1, 16'h4);
    wr(6'h18, 2'h1, 16'h4);
    wr(6'h2a, 2'h1, 16'h1);
    for (int i = 0; i < 3; i++)
    begin
      if (i == 2)
        wr(6'h28, 2'h1, 16'h8);
      v = 16'($urandom);
      wr(6'h1b, 2'h3, v);
      req_a = 5'h8;
      tick(8);
      req_a = 5'h0;
      tick(8);
      if (i < 2)
      begin
        mir[30] = mir[28];
        mir[28] = v;
      end
      rd(6'h1c);
      check("capture", q, mir[28]);
      rd(6'h1e);
      check("cap_buf", q, mir[30]);
    end
    check("cap_flag", 16'(flags_o[9]), 16'h1);
    // channel 1 register B captures on falling edges only; its clock input D is idle
    wr(6'h9, 2'h1, 16'h50);
    v = 16'($urandom);
    wr(6'hb, 2'h3, v);
    wr(6'ha, 2'h1, 16'h0);
    req_b = 5'h2;
    tick(8);
    check("cap_b_rise", 16'(flags_o[4]), 16'h0);
    req_b = 5'h0;
    tick(8);
    rd(6'hd);
    check("cap_b", q, v);
    check("cap_b_flag", 16'(flags_o[4]), 16'h1);
    standby = 1'b1;
    tick(1);
    standby = 1'b0;
    mir_init();
    scan(0, 32);
    results();
  end
endmodule

// >>> pkg/tcc_pkg.sv
// Overview of operation
// - two 16-bit read/write general registers per channel
// - compare role: equality sets A/B flag
// - capture role: chosen edge latches counter, sets flag
// - io control ignored in any PWM mode
// - reset/standby: compare role, value ffff
// - word and byte access on 16-bit bus
// - buffer registers only on channels 3, 4
// - four separate buffer enable bits
// - buffer follows role of its general register
// - buffers reset to ffff
// - control register resets 80, bit 7 reads 1
// - clear select: none, A, B, sync group
// - clear event is match or capture by role
// - external edge select: rise, fall, both
// - prescaler picks internal divider or external input
// - internal clock counts falling edges only
// - channel 2 phase counting overrides clock selection
// - 16-bit counter counts selected clock source
// - overflow or underflow sets overflow flag
package tcc_pkg;
  localparam int         NCH        = 5;
  localparam int         CH_STRIDE  = 8;
  localparam logic [2:0] OFS_CTRL   = 3'h0;
  localparam logic [2:0] OFS_IOC    = 3'h1;
  localparam logic [2:0] OFS_FLAGS  = 3'h2;
  localparam logic [2:0] OFS_CNT    = 3'h3;
  localparam logic [2:0] OFS_GRA    = 3'h4;
  localparam logic [2:0] OFS_GRB    = 3'h5;
  localparam logic [2:0] OFS_BRA    = 3'h6;
  localparam logic [2:0] OFS_BRB    = 3'h7;
  localparam logic [5:0] OFS_MODE   = 6'h28;
  localparam logic [5:0] OFS_SYNC   = 6'h29;
  localparam logic [5:0] OFS_FUNC   = 6'h2a;
  localparam logic [7:0] RST_CTRL   = 8'h80;
  localparam logic [7:0] RST_IOC    = 8'h88;
  localparam logic [7:0] RST_MODE   = 8'h00;
  localparam logic [4:0] RST_SYNC   = 5'h00;
  localparam logic [3:0] RST_FUNC   = 4'h0;
  localparam logic [2:0] RST_FLAGS  = 3'h0;
  localparam logic [4:0] FLAGS_RO   = 5'h1f;
  localparam logic [15:0] RST_GR    = 16'hffff;
  localparam logic [15:0] RST_CNT   = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hffff;
  localparam int         PSC_HI     = 2;
  localparam int         EDGE_LO    = 3;
  localparam int         CLR_LO     = 5;
  localparam int         IOC_STRIDE = 4;
  localparam int         IOC_CAP    = 2;
  localparam int         FLG_OVF    = 2;
  localparam int         MODE_PHASE = 5;
  localparam int         MODE_CPWM  = 6;
  localparam int         FIRST_BUF  = 3;
  localparam int         PHASE_CH   = 2;
  localparam int         PSC_W      = 3;
  localparam int         NPIN       = 14;
  typedef enum logic [1:0] {
    TCC_CLR_NONE = 2'b00,
    TCC_CLR_A    = 2'b01,
    TCC_CLR_B    = 2'b10,
    TCC_CLR_SYNC = 2'b11
  } tcc_clr_type;
endpackage

// >>> src/tcc_pin_sync.sv
`timescale 1ns/1ps
module tcc_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);
  if (W < 1)
  begin : g_chk
    $error("tcc_pin_sync: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++)
  begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
      end
      else if (ce)
      begin
        s1_r <= pin_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
      end
    end

    // a level change is taken only once two stages agree, filtering one-cycle glitches
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        level_o[i] <= 1'b0;
        rise_o[i]  <= 1'b0;
        fall_o[i]  <= 1'b0;
      end
      else if (ce)
      begin
        rise_o[i] <= (s2_r == s3_r) && s3_r && !level_o[i];
        fall_o[i] <= (s2_r == s3_r) && !s3_r && level_o[i];
        if (s2_r == s3_r)
        begin
          level_o[i] <= s3_r;
        end
      end
    end
  end
endmodule

// >>> src/tcc_top.sv
`timescale 1ns/1ps
module tcc_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        standby,
  input  wire logic [5:0]  bus_addr,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  input  wire logic [1:0]  bus_be,
  input  wire logic [15:0] bus_wdata,
  input  wire logic        ext_clock_a,
  input  wire logic        ext_clock_b,
  input  wire logic        ext_clock_c,
  input  wire logic        ext_clock_d,
  input  wire logic [4:0]  cap_in_a,
  input  wire logic [4:0]  cap_in_b,
  output logic      [15:0] bus_rdata,
  output logic      [14:0] flags_o
);
  localparam int NCH = tcc_pkg::NCH;

  function automatic logic [5:0] reg_addr(input int c, input logic [2:0] ofs);
    reg_addr = 6'(c * tcc_pkg::CH_STRIDE) + {3'h0, ofs};
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // shared by clock edge select and capture edge select: 00 rise, 01 fall, 1x both
  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    edge_hit = sel[1] ? (r | f) : (sel[0] ? f : r);
  endfunction

  logic                        rst;
  logic [tcc_pkg::PSC_W-1:0]   div_r;
  logic [3:0]                  int_tick;
  logic [tcc_pkg::NPIN-1:0]    pin_lvl;
  logic [tcc_pkg::NPIN-1:0]    pin_rise;
  logic [tcc_pkg::NPIN-1:0]    pin_fall;
  logic [7:0]                  ctrl_r [NCH];
  logic [7:0]                  ioc_r [NCH];
  logic [2:0]                  flg_r [NCH];
  logic [15:0]                 cnt_r [NCH];
  logic [15:0]                 gr_r [2*NCH];
  logic [15:0]                 br_r [4];
  logic [2*NCH-1:0]            ev;
  logic [NCH-1:0]              grp_src;
  logic                        grp_clr;
  logic [7:0]                  mode_r;
  logic [4:0]                  sync_r;
  logic [3:0]                  func_r;
  logic [15:0]                 rd_val;

  assign rst = ~rst_n | standby;

  tcc_pin_sync #(
    .W (tcc_pkg::NPIN)
  ) u_pins (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .pin_in  ({cap_in_b, cap_in_a, ext_clock_d, ext_clock_c, ext_clock_b, ext_clock_a}),
    .level_o (pin_lvl),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // free-running divider; bit k falling marks a falling edge of the clock divided by 2^(k+1)
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_r <= '0;
    end
    else if (ce)
    begin
      div_r <= div_r + 3'h1;
    end
  end

  assign int_tick = {&div_r[2:0], &div_r[1:0], div_r[0], 1'b1};

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_r <= tcc_pkg::RST_MODE;
      sync_r <= tcc_pkg::RST_SYNC;
      func_r <= tcc_pkg::RST_FUNC;
    end
    else if (ce && bus_wr && bus_be[0])
    begin
      if (bus_addr == tcc_pkg::OFS_MODE)
      begin
        mode_r <= {1'b0, bus_wdata[6:0]};
      end
      if (bus_addr == tcc_pkg::OFS_SYNC)
      begin
        sync_r <= bus_wdata[4:0];
      end
      if (bus_addr == tcc_pkg::OFS_FUNC)
      begin
        func_r <= bus_wdata[3:0];
      end
    end
  end

  assign grp_clr = |(grp_src & sync_r);

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    localparam bit HAS_BUF = (c >= tcc_pkg::FIRST_BUF);
    logic             pwm;
    logic             tick;
    logic             up;
    logic             dn;
    logic             clr_here;
    logic             wr8;
    logic [2:0]       psc;
    tcc_pkg::tcc_clr_type clr_sel;

    assign pwm = mode_r[c] | (mode_r[tcc_pkg::MODE_CPWM] & HAS_BUF);
    assign psc = ctrl_r[c][tcc_pkg::PSC_HI:0];
    assign clr_sel = tcc_pkg::tcc_clr_type'(ctrl_r[c][tcc_pkg::CLR_LO+1:tcc_pkg::CLR_LO]);
    assign wr8 = bus_wr & bus_be[0];

    // external inputs count on the chosen edges, internal ones on divider falling edges, or every cycle when psc is 0
    assign tick = psc[2]
                ? edge_hit(ctrl_r[c][tcc_pkg::EDGE_LO+1:tcc_pkg::EDGE_LO],
                           pin_rise[psc[1:0]], pin_fall[psc[1:0]])
                : int_tick[psc[1:0]];

    if (c == tcc_pkg::PHASE_CH)
    begin : g_phase
      logic ph;
      logic qa_r;
      logic qa_f;
      logic qb_r;
      logic qb_f;
      assign ph   = mode_r[tcc_pkg::MODE_PHASE];
      assign qa_r = pin_rise[0];
      assign qa_f = pin_fall[0];
      assign qb_r = pin_rise[1];
      assign qb_f = pin_fall[1];
      // input A leading B counts up, B leading A counts down
      assign up = ph ? ((qa_r & ~pin_lvl[1]) | (qa_f & pin_lvl[1]) |
                        (qb_r & pin_lvl[0]) | (qb_f & ~pin_lvl[0])) : tick;
      assign dn = ph & ((qa_r & pin_lvl[1]) | (qa_f & ~pin_lvl[1]) |
                        (qb_r & ~pin_lvl[0]) | (qb_f & pin_lvl[0]));
    end
    else
    begin : g_up
      assign up = tick;
      assign dn = 1'b0;
    end

    assign grp_src[c] = ((clr_sel == tcc_pkg::TCC_CLR_A) & ev[2*c]) |
                        ((clr_sel == tcc_pkg::TCC_CLR_B) & ev[2*c+1]);
    assign clr_here = grp_src[c] |
                      ((clr_sel == tcc_pkg::TCC_CLR_SYNC) & sync_r[c] & grp_clr);

    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        ctrl_r[c] <= tcc_pkg::RST_CTRL;
        ioc_r[c]  <= tcc_pkg::RST_IOC;
      end
      else if (ce && wr8)
      begin
        if (bus_addr == reg_addr(c, tcc_pkg::OFS_CTRL))
        begin
          ctrl_r[c] <= bus_wdata[7:0] | tcc_pkg::RST_CTRL;
        end
        if (bus_addr == reg_addr(c, tcc_pkg::OFS_IOC))
        begin
          ioc_r[c] <= bus_wdata[7:0] | tcc_pkg::RST_IOC;
        end
      end
    end

    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        cnt_r[c] <= tcc_pkg::RST_CNT;
      end
      else if (ce)
      begin
        if (bus_wr && bus_addr == reg_addr(c, tcc_pkg::OFS_CNT))
        begin
          cnt_r[c] <= merge16(cnt_r[c], bus_wdata, bus_be);
        end
        else if (clr_here)
        begin
          cnt_r[c] <= tcc_pkg::RST_CNT;
        end
        else if (up)
        begin
          cnt_r[c] <= cnt_r[c] + 16'h0001;
        end
        else if (dn)
        begin
          cnt_r[c] <= cnt_r[c] - 16'h0001;
        end
      end
    end

    // hardware sets win over a software clear in the same cycle
    always_ff @(posedge ref_clk)
    begin
      if (rst)
      begin
        flg_r[c] <= tcc_pkg::RST_FLAGS;
      end
      else if (ce)
      begin
        flg_r[c] <= ((wr8 && bus_addr == reg_addr(c, tcc_pkg::OFS_FLAGS))
                     ? (flg_r[c] & bus_wdata[2:0]) : flg_r[c])
                  | {(up & ~dn & ~clr_here & (cnt_r[c] == tcc_pkg::CNT_MAX)) |
                     (dn & ~clr_here & (cnt_r[c] == tcc_pkg::RST_CNT)),
                     ev[2*c+1], ev[2*c]};
      end
    end

    assign flags_o[3*c +: 3] = flg_r[c];

    for (genvar k = 0; k < 2; k++)
    begin : g_ab
      localparam int R = 2 * c + k;
      logic        cap;
      logic        cmp;
      logic        cpt;
      logic        eq_r;
      logic        bufe;
      logic [15:0] br_val;
      logic [1:0]  esel;

      assign esel = ioc_r[c][tcc_pkg::IOC_STRIDE*k +: 2];
      assign cap  = ioc_r[c][tcc_pkg::IOC_STRIDE*k + tcc_pkg::IOC_CAP] & ~pwm;
      // only the first cycle of equality counts, so a stopped counter flags once
      assign cmp  = ~cap & (cnt_r[c] == gr_r[R]) & ~eq_r;
      assign cpt  = cap & edge_hit(esel, pin_rise[4+c+NCH*k], pin_fall[4+c+NCH*k]);
      assign ev[R] = cap ? cpt : cmp;

      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          eq_r <= 1'b0;
        end
        else if (ce)
        begin
          eq_r <= (cnt_r[c] == gr_r[R]);
        end
      end

      if (HAS_BUF)
      begin : g_buf
        localparam int B = R - 2 * tcc_pkg::FIRST_BUF;
        assign bufe   = func_r[B];
        assign br_val = br_r[B];

        always_ff @(posedge ref_clk)
        begin
          if (rst)
          begin
            br_r[B] <= tcc_pkg::RST_GR;
          end
          else if (ce)
          begin
            if (bus_wr && bus_addr == reg_addr(c, tcc_pkg::OFS_BRA + 3'(k)))
            begin
              br_r[B] <= merge16(br_r[B], bus_wdata, bus_be);
            end
            else if (cpt && bufe)
            begin
              br_r[B] <= gr_r[R];
            end
          end
        end
      end
      else
      begin : g_nobuf
        assign bufe   = 1'b0;
        assign br_val = tcc_pkg::RST_GR;
      end

      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          gr_r[R] <= tcc_pkg::RST_GR;
        end
        else if (ce)
        begin
          if (bus_wr && bus_addr == reg_addr(c, tcc_pkg::OFS_GRA + 3'(k)))
          begin
            gr_r[R] <= merge16(gr_r[R], bus_wdata, bus_be);
          end
          else if (cpt)
          begin
            gr_r[R] <= cnt_r[c];
          end
          else if (cmp && bufe)
          begin
            gr_r[R] <= br_val;
          end
        end
      end
    end
  end

  // unmapped addresses and byte-wide registers' upper byte read as zero
  always_comb
  begin
    rd_val = '0;
    if (bus_addr == tcc_pkg::OFS_MODE)
    begin
      rd_val = {8'h00, mode_r};
    end
    if (bus_addr == tcc_pkg::OFS_SYNC)
    begin
      rd_val = {11'h000, sync_r};
    end
    if (bus_addr == tcc_pkg::OFS_FUNC)
    begin
      rd_val = {12'h000, func_r};
    end
    for (int c = 0; c < NCH; c++)
    begin
      if (bus_addr == reg_addr(c, tcc_pkg::OFS_CTRL))
      begin
        rd_val = {8'h00, ctrl_r[c]};
      end
      if (bus_addr == reg_addr(c, tcc_pkg::OFS_IOC))
      begin
        rd_val = {8'h00, ioc_r[c]};
      end
      if (bus_addr == reg_addr(c, tcc_pkg::OFS_FLAGS))
      begin
        rd_val = {8'h00, tcc_pkg::FLAGS_RO, flg_r[c]};
      end
      if (bus_addr == reg_addr(c, tcc_pkg::OFS_CNT))
      begin
        rd_val = cnt_r[c];
      end
      if (bus_addr == reg_addr(c, tcc_pkg::OFS_GRA))
      begin
        rd_val = gr_r[2*c];
      end
      if (bus_addr == reg_addr(c, tcc_pkg::OFS_GRB))
      begin
        rd_val = gr_r[2*c+1];
      end
      if (c >= tcc_pkg::FIRST_BUF && bus_addr == reg_addr(c, tcc_pkg::OFS_BRA))
      begin
        rd_val = br_r[2'(2*(c-tcc_pkg::FIRST_BUF))];
      end
      if (c >= tcc_pkg::FIRST_BUF && bus_addr == reg_addr(c, tcc_pkg::OFS_BRB))
      begin
        rd_val = br_r[2'(2*(c-tcc_pkg::FIRST_BUF)+1)];
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      bus_rdata <= '0;
    end
    else if (ce && bus_rd)
    begin
      bus_rdata <= rd_val;
    end
  end
endmodule
